// file: rtl/rtcs_slave_port.sv
// Two-wire slave port of the clock/RAM device: bus sequencer and core interface
`timescale 1ns/10ps
module rtcs_slave_port #(
  parameter logic [6:0] SLAVE_ADDR = rtcs_pkg::SLAVE_ADDR_DEF
) (
  // Core clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // Bus side
  input  wire logic       link_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Core write port
  output logic            wr_stb_o,
  output logic [5:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  // Core read port
  output logic [5:0]      rd_addr_o,
  input  wire logic [7:0] rd_data_i,
  // Time snapshot
  output logic            snapshot_o
);

  generate
    if (rtcs_pkg::PTR_W != 6) begin : g_bad_ptr
      $error("rtcs_slave_port: pointer width must be 6");
    end
  endgenerate

  typedef struct packed {
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_d;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_d;
    rtcs_pkg::rtcs_state_t state;
    logic [3:0]            cnt;
    logic [7:0]            sh;
    logic [7:0]            tx;
    logic                  rw;
    logic                  ptr_phase;
    logic [5:0]            ptr;
    logic                  oe;
    logic [7:0]            rd_buf;
    logic                  wr_vld;
    logic [13:0]           wr_word;
    logic                  rdq_vld;
    logic                  snap_vld;
  } rtcs_link_t;

  typedef struct packed {
    logic       wr_stb;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [5:0] rd_addr;
    logic       rd_pend;
    logic       snap;
  } rtcs_sys_t;

  localparam rtcs_link_t LINK_RST = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
    state: rtcs_pkg::ST_IDLE, cnt: rtcs_pkg::BIT_CNT_0,
    sh: 8'h00, tx: 8'h00, rw: 1'b0, ptr_phase: 1'b0,
    ptr: rtcs_pkg::PTR_RST, oe: 1'b0, rd_buf: 8'h00,
    wr_vld: 1'b0, wr_word: 14'h0000, rdq_vld: 1'b0, snap_vld: 1'b0
  };

  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    ptr_inc = (p == rtcs_pkg::PTR_LAST) ? rtcs_pkg::PTR_FIRST : p + 6'h01;
  endfunction

  rtcs_link_t l_reg, l_next;
  rtcs_sys_t  s_reg, s_next;

  logic        start_ev;
  logic        stop_ev;
  logic        scl_rise;
  logic        scl_fall;
  logic        ptr_adv;
  logic        wr_vld_sys;
  logic [13:0] wr_word_sys;
  logic        rdq_vld_sys;
  logic [5:0]  rdq_addr_sys;
  logic        rep_vld;
  logic [7:0]  rep_data;
  logic        snap_vld_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings between bus side and core side

  rtcs_hs_cdc #(.W(14)) u_wr_cdc (
    .src_clk_i  (link_clk_i),
    .dst_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .src_vld_i  (l_reg.wr_vld),
    .src_data_i (l_reg.wr_word),
    .src_busy_o (),
    .dst_vld_o  (wr_vld_sys),
    .dst_data_o (wr_word_sys)
  );

  rtcs_hs_cdc #(.W(6)) u_rdq_cdc (
    .src_clk_i  (link_clk_i),
    .dst_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .src_vld_i  (l_reg.rdq_vld),
    .src_data_i (l_reg.ptr),
    .src_busy_o (),
    .dst_vld_o  (rdq_vld_sys),
    .dst_data_o (rdq_addr_sys)
  );

  rtcs_hs_cdc #(.W(8)) u_rep_cdc (
    .src_clk_i  (sys_clk_i),
    .dst_clk_i  (link_clk_i),
    .reset_i    (reset_i),
    .src_vld_i  (s_reg.rd_pend),
    .src_data_i (rd_data_i),
    .src_busy_o (),
    .dst_vld_o  (rep_vld),
    .dst_data_o (rep_data)
  );

  rtcs_hs_cdc #(.W(1)) u_snap_cdc (
    .src_clk_i  (link_clk_i),
    .dst_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .src_vld_i  (l_reg.snap_vld),
    .src_data_i (1'b1),
    .src_busy_o (),
    .dst_vld_o  (snap_vld_sys),
    .dst_data_o ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions, from synchronised lines only
  assign start_ev = l_reg.scl_s2 && l_reg.scl_d && l_reg.sda_d && !l_reg.sda_s2;
  assign stop_ev  = l_reg.scl_s2 && l_reg.scl_d && !l_reg.sda_d && l_reg.sda_s2;
  assign scl_rise = l_reg.scl_s2 && !l_reg.scl_d;
  assign scl_fall = !l_reg.scl_s2 && l_reg.scl_d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer
  always_comb begin
    l_next          = l_reg;
    l_next.scl_s1   = scl_i;
    l_next.scl_s2   = l_reg.scl_s1;
    l_next.scl_d    = l_reg.scl_s2;
    l_next.sda_s1   = sda_i;
    l_next.sda_s2   = l_reg.sda_s1;
    l_next.sda_d    = l_reg.sda_s2;
    l_next.wr_vld   = 1'b0;
    l_next.rdq_vld  = 1'b0;
    l_next.snap_vld = 1'b0;
    ptr_adv         = 1'b0;
    if (rep_vld) begin
      l_next.rd_buf = rep_data;
    end
    if (start_ev) begin
      // Repeated START lands here too, from any state
      l_next.state     = rtcs_pkg::ST_ADDR;
      l_next.cnt       = rtcs_pkg::BIT_CNT_0;
      l_next.oe        = 1'b0;
      l_next.ptr_phase = 1'b0;
      l_next.snap_vld  = 1'b1;
    end else if (stop_ev) begin
      l_next.state = rtcs_pkg::ST_IDLE;
      l_next.oe    = 1'b0;
    end else begin
      if (scl_rise && ((l_reg.state == rtcs_pkg::ST_ADDR) ||
                       (l_reg.state == rtcs_pkg::ST_RX))) begin
        l_next.sh  = {l_reg.sh[6:0], l_reg.sda_s2};
        l_next.cnt = l_reg.cnt + rtcs_pkg::BIT_CNT_1;
      end
      unique case (l_reg.state)
        rtcs_pkg::ST_IDLE, rtcs_pkg::ST_IGNORE: begin
          l_next.oe = 1'b0;
        end
        rtcs_pkg::ST_ADDR: begin
          if (scl_fall && (l_reg.cnt == rtcs_pkg::BYTE_BITS)) begin
            if (l_reg.sh[7:1] == SLAVE_ADDR) begin
              l_next.oe    = 1'b1;
              l_next.rw    = l_reg.sh[0];
              l_next.state = rtcs_pkg::ST_ADDR_ACK;
              // Prefetch the first read byte during the ack slot
              l_next.rdq_vld = (l_reg.sh[0] == rtcs_pkg::DIR_READ);
            end else begin
              l_next.state = rtcs_pkg::ST_IGNORE;
            end
          end
        end
        rtcs_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            l_next.cnt = rtcs_pkg::BIT_CNT_0;
            if (l_reg.rw == rtcs_pkg::DIR_READ) begin
              l_next.tx    = l_reg.rd_buf;
              l_next.oe    = ~l_reg.rd_buf[7];
              l_next.state = rtcs_pkg::ST_TX;
            end else begin
              l_next.oe        = 1'b0;
              l_next.ptr_phase = 1'b1;
              l_next.state     = rtcs_pkg::ST_RX;
            end
          end
        end
        rtcs_pkg::ST_RX: begin
          if (scl_fall && (l_reg.cnt == rtcs_pkg::BYTE_BITS)) begin
            l_next.oe    = 1'b1;
            l_next.state = rtcs_pkg::ST_RX_ACK;
            if (l_reg.ptr_phase) begin
              l_next.ptr       = l_reg.sh[5:0];
              l_next.ptr_phase = 1'b0;
            end else begin
              l_next.wr_vld  = 1'b1;
              l_next.wr_word = {l_reg.ptr, l_reg.sh};
              l_next.ptr     = ptr_inc(l_reg.ptr);
              ptr_adv        = 1'b1;
            end
          end
        end
        rtcs_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            l_next.oe    = 1'b0;
            l_next.cnt   = rtcs_pkg::BIT_CNT_0;
            l_next.state = rtcs_pkg::ST_RX;
          end
        end
        rtcs_pkg::ST_TX: begin
          if (scl_rise) begin
            l_next.cnt = l_reg.cnt + rtcs_pkg::BIT_CNT_1;
          end
          if (scl_fall) begin
            if (l_reg.cnt == rtcs_pkg::BYTE_BITS) begin
              l_next.oe      = 1'b0;
              l_next.state   = rtcs_pkg::ST_TX_ACK;
              l_next.ptr     = ptr_inc(l_reg.ptr);
              ptr_adv        = 1'b1;
              l_next.rdq_vld = 1'b1;
            end else begin
              l_next.tx = {l_reg.tx[6:0], 1'b0};
              l_next.oe = ~l_reg.tx[6];
            end
          end
        end
        rtcs_pkg::ST_TX_ACK: begin
          if (scl_rise && l_reg.sda_s2) begin
            l_next.state = rtcs_pkg::ST_IGNORE;
          end else if (scl_fall) begin
            l_next.cnt   = rtcs_pkg::BIT_CNT_0;
            l_next.tx    = l_reg.rd_buf;
            l_next.oe    = ~l_reg.rd_buf[7];
            l_next.state = rtcs_pkg::ST_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      l_reg <= LINK_RST;
    end else begin
      l_reg <= l_next;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = l_reg.oe;

  ////////////////////////////////////////////////////////////////////////////
  // Core side
  always_comb begin
    s_next         = s_reg;
    s_next.wr_stb  = wr_vld_sys;
    s_next.snap    = snap_vld_sys;
    s_next.rd_pend = rdq_vld_sys;
    if (wr_vld_sys) begin
      s_next.wr_addr = wr_word_sys[13:8];
      s_next.wr_data = wr_word_sys[7:0];
    end
    // Read data is taken one cycle after the address settles
    if (rdq_vld_sys) begin
      s_next.rd_addr = rdq_addr_sys;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wr_stb_o   = s_reg.wr_stb;
  assign wr_addr_o  = s_reg.wr_addr;
  assign wr_data_o  = s_reg.wr_data;
  assign rd_addr_o  = s_reg.rd_addr;
  assign snapshot_o = s_reg.snap;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the bus side, plus the core-side snapshot strobe
  a_start_to_addr: assert property (@(posedge link_clk_i) disable iff (reset_i)
    start_ev |=> (l_reg.state == rtcs_pkg::ST_ADDR) && !sda_oe_o && l_reg.snap_vld)
    else $error("START did not open an address phase");

  a_stop_to_idle: assert property (@(posedge link_clk_i) disable iff (reset_i)
    (stop_ev && !start_ev) |=> (l_reg.state == rtcs_pkg::ST_IDLE) && !sda_oe_o)
    else $error("STOP did not return to idle");

  a_idle_released: assert property (@(posedge link_clk_i) disable iff (reset_i)
    (l_reg.state == rtcs_pkg::ST_IDLE) |-> !sda_oe_o)
    else $error("SDA driven while idle");

  a_addr_ack: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ((l_reg.state == rtcs_pkg::ST_ADDR) && scl_fall && !start_ev && !stop_ev &&
     (l_reg.cnt == rtcs_pkg::BYTE_BITS) && (l_reg.sh[7:1] == SLAVE_ADDR))
    |=> sda_oe_o && (l_reg.state == rtcs_pkg::ST_ADDR_ACK))
    else $error("Matching address not acknowledged");

  a_nomatch_quiet: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ((l_reg.state == rtcs_pkg::ST_ADDR) && scl_fall && !start_ev && !stop_ev &&
     (l_reg.cnt == rtcs_pkg::BYTE_BITS) && (l_reg.sh[7:1] != SLAVE_ADDR))
    |=> !sda_oe_o && (l_reg.state == rtcs_pkg::ST_IGNORE))
    else $error("Foreign address touched SDA");

  a_ack_held: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ((l_reg.state == rtcs_pkg::ST_RX_ACK) && scl_rise) |-> sda_oe_o ##1 sda_oe_o)
    else $error("Ack released during SCL high");

  a_ptr_load: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ((l_reg.state == rtcs_pkg::ST_RX) && scl_fall && l_reg.ptr_phase && !start_ev &&
     !stop_ev && (l_reg.cnt == rtcs_pkg::BYTE_BITS)) |=> (l_reg.ptr == $past(l_reg.sh[5:0])))
    else $error("Pointer byte not loaded");

  a_ptr_wrap: assert property (@(posedge link_clk_i) disable iff (reset_i)
    (ptr_adv && (l_reg.ptr == rtcs_pkg::PTR_LAST)) |=> (l_reg.ptr == rtcs_pkg::PTR_FIRST))
    else $error("Pointer did not wrap to zero");

  a_tx_msb_first: assert property (@(posedge link_clk_i) disable iff (reset_i)
    (l_reg.state == rtcs_pkg::ST_TX) |-> (sda_oe_o == ~l_reg.tx[7]))
    else $error("Transmit bit not taken from MSB");

  a_nack_ends: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ((l_reg.state == rtcs_pkg::ST_TX_ACK) && scl_rise && l_reg.sda_s2 && !start_ev && !stop_ev)
    |=> (l_reg.state == rtcs_pkg::ST_IGNORE) && !sda_oe_o)
    else $error("Not-acknowledge did not end the read");

  a_snap_pulse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    snapshot_o |=> !snapshot_o)
    else $error("Snapshot strobe longer than one cycle");

  c_write_byte: cover property (@(posedge link_clk_i) disable iff (reset_i)
    l_reg.wr_vld);
  c_read_ack: cover property (@(posedge link_clk_i) disable iff (reset_i)
    (l_reg.state == rtcs_pkg::ST_TX_ACK) && scl_fall);
  c_foreign: cover property (@(posedge link_clk_i) disable iff (reset_i)
    l_reg.state == rtcs_pkg::ST_IGNORE);
  c_rep_start: cover property (@(posedge link_clk_i) disable iff (reset_i)
    start_ev && (l_reg.state != rtcs_pkg::ST_IDLE));

endmodule // rtcs_slave_port

// file: rtl/rtcs_pkg.sv
// Shared constants and types of the two-wire slave port
package rtcs_pkg;

  // Register pointer space
  localparam int          PTR_W     = 6;
  localparam logic [5:0]  PTR_FIRST = 6'h00;
  localparam logic [5:0]  PTR_LAST  = 6'h3f;
  localparam logic [5:0]  PTR_RST   = 6'h00;

  // Byte framing
  localparam int          BYTE_W    = 8;
  localparam logic [3:0]  BIT_CNT_0 = 4'h0;
  localparam logic [3:0]  BIT_CNT_1 = 4'h1;
  localparam logic [3:0]  BYTE_BITS = 4'h8;
  localparam logic        DIR_READ  = 1'b1;

  // Slave address default; value is arbitrary
  localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h2a;

  // Bus-side sequencer states
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_ADDR     = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_RX       = 8'h08,
    ST_RX_ACK   = 8'h10,
    ST_TX       = 8'h20,
    ST_TX_ACK   = 8'h40,
    ST_IGNORE   = 8'h80
  } rtcs_state_t;

endpackage

// file: rtl/rtcs_hs_cdc.sv
// Toggle handshake that carries one word from one clock domain to another
`timescale 1ns/10ps
module rtcs_hs_cdc #(
  parameter int W = 8
) (
  // Clocks and reset
  input  wire logic         src_clk_i,
  input  wire logic         dst_clk_i,
  input  wire logic         reset_i,
  // Source side
  input  wire logic         src_vld_i,
  input  wire logic [W-1:0] src_data_i,
  output logic              src_busy_o,
  // Destination side
  output logic              dst_vld_o,
  output logic [W-1:0]      dst_data_o
);

  generate
    if (W < 1) begin : g_bad_w
      $error("rtcs_hs_cdc: W must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic         req;
    logic         ack_s1;
    logic         ack_s2;
    logic [W-1:0] data;
  } rtcs_src_t;

  typedef struct packed {
    logic         req_s1;
    logic         req_s2;
    logic         req_d;
    logic         vld;
    logic [W-1:0] data;
  } rtcs_dst_t;

  rtcs_src_t s_reg, s_next;
  rtcs_dst_t d_reg, d_next;

  ////////////////////////////////////////////////////////////////////////////
  // Source domain: word held stable until the toggle comes back
  always_comb begin
    s_next        = s_reg;
    s_next.ack_s1 = d_reg.req_d;
    s_next.ack_s2 = s_reg.ack_s1;
    // A launch while busy is dropped; the caller spaces its words
    if (src_vld_i && (s_reg.req == s_reg.ack_s2)) begin
      s_next.req  = ~s_reg.req;
      s_next.data = src_data_i;
    end
  end

  always_ff @(posedge src_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign src_busy_o = (s_reg.req != s_reg.ack_s2);

  ////////////////////////////////////////////////////////////////////////////
  // Destination domain
  always_comb begin
    d_next        = d_reg;
    d_next.req_s1 = s_reg.req;
    d_next.req_s2 = d_reg.req_s1;
    d_next.req_d  = d_reg.req_s2;
    d_next.vld    = (d_reg.req_s2 != d_reg.req_d);
    if (d_reg.req_s2 != d_reg.req_d) begin
      d_next.data = s_reg.data;
    end
  end

  always_ff @(posedge dst_clk_i or posedge reset_i) begin
    if (reset_i) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign dst_vld_o  = d_reg.vld;
  assign dst_data_o = d_reg.data;

endmodule // rtcs_hs_cdc

// file: test/rtcs_bus_master.sv
// Behavioural two-wire bus master driving the slave port
`timescale 1ns/10ps
module rtcs_bus_master #(
  parameter int HALF = 20
) (
  // Clock
  input  wire logic clk_i,
  // Bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // Phases shortened from standard mode to keep runs short; still far above sampling needs
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Sampled at both ends of the high phase; a change shows as unknown
  task automatic bit_x(input logic tx, output logic rx);
    logic first;
    wait_clk(HALF/2);
    sda_pull_o <= ~tx;
    wait_clk(HALF/2);
    scl_o <= 1'b1;
    @(posedge clk_i);
    first = sda_i;
    wait_clk(HALF-1);
    rx = (first === sda_i) ? first : 1'bx;
    scl_o <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ack_in, ack_out);
  endtask

  task automatic start;
    sda_pull_o <= 1'b0;
    wait_clk(HALF/2);
    scl_o <= 1'b1;
    wait_clk(HALF);
    sda_pull_o <= 1'b1;
    wait_clk(HALF);
    scl_o <= 1'b0;
  endtask

  task automatic stop;
    sda_pull_o <= 1'b1;
    wait_clk(HALF/2);
    scl_o <= 1'b1;
    wait_clk(HALF);
    sda_pull_o <= 1'b0;
    wait_clk(2*HALF);
  endtask
endmodule // rtcs_bus_master

// file: test/rtcs_slave_port_test.sv
// Self-checking bench of the two-wire slave port
`timescale 1ns/10ps
module rtcs_slave_port_test;
  localparam logic [6:0] ADDR = rtcs_pkg::SLAVE_ADDR_DEF;
  logic       sys_clk_i, link_clk_i, reset_i, scl, sda_pull, sda_line, sda_o, sda_oe;
  logic       wr_stb, snapshot;
  logic [5:0] wr_addr, rd_addr, ptr;
  logic [7:0] wr_data, rd_data;
  logic [7:0] mem [64];
  logic [7:0] exp_mem [64];
  int         miscompares, checks, seed, strobes, exp_strobes, snaps, starts;

  assign sda_line = ~(sda_oe | sda_pull);
  // Core read is combinational, as the port samples one edge after the address moves
  assign rd_data = mem[rd_addr];

  rtcs_slave_port rtcs_slave_port_i (
    .sys_clk_i (sys_clk_i), .reset_i (reset_i), .link_clk_i (link_clk_i),
    .scl_i (scl), .sda_i (sda_line), .sda_o (sda_o), .sda_oe_o (sda_oe),
    .wr_stb_o (wr_stb), .wr_addr_o (wr_addr), .wr_data_o (wr_data),
    .rd_addr_o (rd_addr), .rd_data_i (rd_data), .snapshot_o (snapshot));

  rtcs_bus_master #(.HALF(20)) rtcs_bus_master_i (
    .clk_i (sys_clk_i), .sda_i (sda_line), .scl_o (scl), .sda_pull_o (sda_pull));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #1.7;
    forever #3 link_clk_i = ~link_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (wr_stb === 1'b1) begin
      mem[wr_addr] <= wr_data;
      strobes++;
    end
    if (snapshot === 1'b1) snaps++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [5:0] next_ptr(input logic [5:0] p);
    return p + 6'h01;
  endfunction

  task automatic begin_txn(input logic [6:0] a, input logic dir, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    rtcs_bus_master_i.start();
    starts++;
    rtcs_bus_master_i.xfer({a, dir}, 1'b1, rx, ack);
    check(ack, exp_ack);
  endtask

  task automatic set_ptr(input logic [5:0] p);
    logic [7:0] rx, hi;
    logic       ack;
    begin_txn(ADDR, 1'b0, 1'b0);
    hi = 8'($random(seed));
    rtcs_bus_master_i.xfer({hi[7:6], p}, 1'b1, rx, ack);
    check(ack, 1'b0);
    ptr = p;
  endtask

  task automatic write_txn(input logic [5:0] p, input int n);
    logic [7:0] d, rx;
    logic       ack;
    set_ptr(p);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      rtcs_bus_master_i.xfer(d, 1'b1, rx, ack);
      check(ack, 1'b0);
      exp_mem[ptr] = d;
      ptr = next_ptr(ptr);
      exp_strobes++;
    end
    rtcs_bus_master_i.stop();
  endtask

  task automatic read_txn(input logic load, input logic [5:0] p, input int n);
    logic [7:0] rx;
    logic       ack;
    if (load) set_ptr(p);
    begin_txn(ADDR, rtcs_pkg::DIR_READ, 1'b0);
    for (int i = 0; i < n; i++) begin
      rtcs_bus_master_i.xfer(8'hff, (i == n - 1), rx, ack);
      check(rx, exp_mem[ptr]);
      ptr = next_ptr(ptr);
    end
    repeat (10) @(posedge sys_clk_i);
    check(sda_oe, 1'b0);
    check(sda_o, 1'b0);
    rtcs_bus_master_i.stop();
  endtask

  task automatic foreign_txn;
    logic [7:0] rx;
    logic       ack;
    begin_txn(ADDR ^ 7'h01, 1'b0, 1'b1);
    rtcs_bus_master_i.xfer(8'($random(seed)), 1'b1, rx, ack);
    check(ack, 1'b1);
    rtcs_bus_master_i.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r;
    seed = 32'h96ab;
    reset_i = 1'b1;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'($random(seed));
      exp_mem[i] = mem[i];
    end
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    write_txn(6'h3e, 3);
    read_txn(1'b0, 6'h00, 2);
    read_txn(1'b1, 6'h3f, 3);
    foreign_txn();
    read_txn(1'b0, 6'h00, 1);
    for (int k = 0; k < 6; k++) begin
      r = 8'($random(seed));
      write_txn(r[5:0], int'(r[7:6]) + 1);
      read_txn(1'b1, r[5:0], int'(r[7:6]) + 1);
    end
    check(8'(strobes), 8'(exp_strobes));
    check(8'(snaps), 8'(starts));
    for (int i = 0; i < 64; i++) check(mem[i], exp_mem[i]);
    end_sim();
  end

  initial begin
    repeat (80000) @(posedge sys_clk_i);
    miscompares++;
    end_sim();
  end
endmodule // rtcs_slave_port_test
